/* simd_alu_pkg.sv */
// Shared constants and operation codes for the packed integer datapath
package simd_alu_pkg;

    localparam int unsigned DATA_W = 64;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned DWORD_W = 32;
    localparam int unsigned N_BYTES = DATA_W / BYTE_W;
    localparam int unsigned N_WORDS = DATA_W / WORD_W;
    localparam int unsigned N_DWORDS = DATA_W / DWORD_W;
    localparam int unsigned OP_W = 6;

    // Shift counts at or above these limits zero the lane, or fill it with the sign bit on arithmetic right shifts
    localparam logic [63:0] WORD_LIMIT = 64'h10;
    localparam logic [63:0] DWORD_LIMIT = 64'h20;
    localparam logic [63:0] QUAD_LIMIT = 64'h40;

    localparam logic [63:0] RESULT_RST = 64'h0;
    localparam logic VALID_RST = 1'b0;
    localparam logic EMPTY_RST = 1'b1;

    typedef enum logic [5:0] {
        MOVE_DOUBLE_WORD = 6'h00,
        MOVE_QUAD_WORD = 6'h01,
        PACK_SIGNED_WORD_TO_BYTE = 6'h02,
        PACK_SIGNED_DWORD_TO_WORD = 6'h03,
        PACK_UNSIGNED_WORD_TO_BYTE = 6'h04,
        INTERLEAVE_HIGH_BYTES = 6'h05,
        INTERLEAVE_HIGH_WORDS = 6'h06,
        INTERLEAVE_HIGH_DWORDS = 6'h07,
        INTERLEAVE_LOW_BYTES = 6'h08,
        INTERLEAVE_LOW_WORDS = 6'h09,
        INTERLEAVE_LOW_DWORDS = 6'h0a,
        LANE_ADD_BYTE = 6'h0b,
        LANE_ADD_WORD = 6'h0c,
        LANE_ADD_DWORD = 6'h0d,
        SAT_SIGNED_ADD_BYTE = 6'h0e,
        SAT_SIGNED_ADD_WORD = 6'h0f,
        SAT_UNSIGNED_ADD_BYTE = 6'h10,
        SAT_UNSIGNED_ADD_WORD = 6'h11,
        LANE_SUB_BYTE = 6'h12,
        LANE_SUB_WORD = 6'h13,
        LANE_SUB_DWORD = 6'h14,
        SAT_SIGNED_SUB_BYTE = 6'h15,
        SAT_SIGNED_SUB_WORD = 6'h16,
        SAT_UNSIGNED_SUB_BYTE = 6'h17,
        SAT_UNSIGNED_SUB_WORD = 6'h18,
        MUL_WORD_HIGH_HALF = 6'h19,
        MUL_WORD_LOW_HALF = 6'h1a,
        MUL_ADD_WORD_PAIRS = 6'h1b,
        CMP_EQUAL_BYTE = 6'h1c,
        CMP_EQUAL_WORD = 6'h1d,
        CMP_EQUAL_DWORD = 6'h1e,
        CMP_GREATER_BYTE = 6'h1f,
        CMP_GREATER_WORD = 6'h20,
        CMP_GREATER_DWORD = 6'h21,
        BITWISE_AND_QUAD = 6'h22,
        BITWISE_AND_INVERTED = 6'h23,
        BITWISE_OR_QUAD = 6'h24,
        BITWISE_XOR_QUAD = 6'h25,
        SHL_LOGICAL_WORD = 6'h26,
        SHL_LOGICAL_DWORD = 6'h27,
        SHL_LOGICAL_QUAD = 6'h28,
        SHR_LOGICAL_WORD = 6'h29,
        SHR_LOGICAL_DWORD = 6'h2a,
        SHR_LOGICAL_QUAD = 6'h2b,
        SHR_ARITH_WORD = 6'h2c,
        SHR_ARITH_DWORD = 6'h2d,
        EMPTY_PACKED_STATE = 6'h2e
    } op_t;

endpackage : simd_alu_pkg

/* lane_addsub.sv */
// One lane of add or subtract with wrapped, signed-clamped and unsigned-clamped results
module lane_addsub #(
    parameter int unsigned W = 8
) (
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    input wire logic i_sub,
    output logic [W-1:0] o_wrap,
    output logic [W-1:0] o_sat_s,
    output logic [W-1:0] o_sat_u
);

    logic [W:0] ext;
    logic ovf;

    always_comb begin
        if (i_sub) begin
            ext = {1'b0, i_a} - {1'b0, i_b};
        end else begin
            ext = {1'b0, i_a} + {1'b0, i_b};
        end
    end

    assign o_wrap = ext[W-1:0];
    // Signed overflow: result sign disagrees with a sign that the operands force
    assign ovf = (i_sub ? (i_a[W-1] != i_b[W-1]) : (i_a[W-1] == i_b[W-1]))
                 && (ext[W-1] != i_a[W-1]);
    assign o_sat_s = !ovf ? ext[W-1:0] : (i_a[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}});
    // Bit W is carry on add and borrow on subtract
    assign o_sat_u = !ext[W] ? ext[W-1:0] : (i_sub ? {W{1'b0}} : {W{1'b1}});

endmodule : lane_addsub

/* packed_simd_integer_alu.sv */
// Packed integer SIMD datapath with one-cycle registered result
module packed_simd_integer_alu
    import simd_alu_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_valid,
    input wire logic [OP_W-1:0] i_op,
    input wire logic [DATA_W-1:0] i_src_a,
    input wire logic [DATA_W-1:0] i_src_b,
    output logic [DATA_W-1:0] o_result,
    output logic o_valid,
    output logic o_state_empty
);

    ////////////////////////////////////////////////////////////////////////////////
    // Lane helpers

    function automatic logic [7:0] sat_s16_s8(input logic [15:0] v);
        if (v[15:7] != {9{v[15]}}) begin
            return v[15] ? 8'h80 : 8'h7f;
        end
        return v[7:0];
    endfunction : sat_s16_s8

    function automatic logic [15:0] sat_s32_s16(input logic [31:0] v);
        if (v[31:15] != {17{v[31]}}) begin
            return v[31] ? 16'h8000 : 16'h7fff;
        end
        return v[15:0];
    endfunction : sat_s32_s16

    function automatic logic [7:0] sat_s16_u8(input logic [15:0] v);
        if (v[15]) begin
            return 8'h00;
        end
        if (|v[14:8]) begin
            return 8'hff;
        end
        return v[7:0];
    endfunction : sat_s16_u8

    ////////////////////////////////////////////////////////////////////////////////
    // Lane datapaths

    logic is_sub;
    logic [63:0] b_wrap, b_ss, b_su, w_wrap, w_ss, w_su, d_wrap;
    logic [63:0] eq_b, eq_w, eq_d, gt_b, gt_w, gt_d;
    logic [63:0] pk_sb, pk_ub, pk_sw;
    logic [63:0] hi_b, lo_b, hi_w, lo_w;
    logic [63:0] mul_hi, mul_lo, mul_add;
    logic [63:0] shl_w, shr_w, sar_w, shl_d, shr_d, sar_d, shl_q, shr_q;
    logic [63:0] result_d;

    assign is_sub = (i_op >= LANE_SUB_BYTE) && (i_op <= SAT_UNSIGNED_SUB_WORD);

    genvar i;
    generate
        for (i = 0; i < N_BYTES; i++) begin : g_byte
            lane_addsub #(.W(BYTE_W)) u_lane (
                .i_a(i_src_a[8*i+:8]),
                .i_b(i_src_b[8*i+:8]),
                .i_sub(is_sub),
                .o_wrap(b_wrap[8*i+:8]),
                .o_sat_s(b_ss[8*i+:8]),
                .o_sat_u(b_su[8*i+:8])
            );
            assign eq_b[8*i+:8] = {8{i_src_a[8*i+:8] == i_src_b[8*i+:8]}};
            assign gt_b[8*i+:8] = {8{$signed(i_src_a[8*i+:8]) > $signed(i_src_b[8*i+:8])}};
        end

        for (i = 0; i < N_WORDS; i++) begin : g_word
            logic [15:0] a_w, b_w;
            logic [31:0] prod;
            assign a_w = i_src_a[16*i+:16];
            assign b_w = i_src_b[16*i+:16];
            lane_addsub #(.W(WORD_W)) u_lane (
                .i_a(a_w),
                .i_b(b_w),
                .i_sub(is_sub),
                .o_wrap(w_wrap[16*i+:16]),
                .o_sat_s(w_ss[16*i+:16]),
                .o_sat_u(w_su[16*i+:16])
            );
            assign eq_w[16*i+:16] = {16{a_w == b_w}};
            assign gt_w[16*i+:16] = {16{$signed(a_w) > $signed(b_w)}};
            assign prod = $signed({{16{a_w[15]}}, a_w}) * $signed({{16{b_w[15]}}, b_w});
            assign mul_hi[16*i+:16] = prod[31:16];
            assign mul_lo[16*i+:16] = prod[15:0];
            // Narrowing: source a fills the low half of the result, b the high half
            assign pk_sb[8*i+:8] = sat_s16_s8(a_w);
            assign pk_sb[32+8*i+:8] = sat_s16_s8(b_w);
            assign pk_ub[8*i+:8] = sat_s16_u8(a_w);
            assign pk_ub[32+8*i+:8] = sat_s16_u8(b_w);
            assign hi_b[16*i+:16] = {i_src_b[32+8*i+:8], i_src_a[32+8*i+:8]};
            assign lo_b[16*i+:16] = {i_src_b[8*i+:8], i_src_a[8*i+:8]};
            assign shl_w[16*i+:16] = (i_src_b >= WORD_LIMIT) ? 16'h0 : a_w << i_src_b[3:0];
            assign shr_w[16*i+:16] = (i_src_b >= WORD_LIMIT) ? 16'h0 : a_w >> i_src_b[3:0];
            assign sar_w[16*i+:16] = (i_src_b >= WORD_LIMIT) ? {16{a_w[15]}}
                                   : 16'($signed(a_w) >>> i_src_b[3:0]);
        end

        for (i = 0; i < N_DWORDS; i++) begin : g_dword
            logic [31:0] a_d, b_d;
            assign a_d = i_src_a[32*i+:32];
            assign b_d = i_src_b[32*i+:32];
            lane_addsub #(.W(DWORD_W)) u_lane (
                .i_a(a_d),
                .i_b(b_d),
                .i_sub(is_sub),
                .o_wrap(d_wrap[32*i+:32]),
                .o_sat_s(),
                .o_sat_u()
            );
            assign eq_d[32*i+:32] = {32{a_d == b_d}};
            assign gt_d[32*i+:32] = {32{$signed(a_d) > $signed(b_d)}};
            assign mul_add[32*i+:32] = g_word[2*i].prod + g_word[2*i+1].prod;
            assign pk_sw[16*i+:16] = sat_s32_s16(a_d);
            assign pk_sw[32+16*i+:16] = sat_s32_s16(b_d);
            assign hi_w[32*i+:32] = {i_src_b[32+16*i+:16], i_src_a[32+16*i+:16]};
            assign lo_w[32*i+:32] = {i_src_b[16*i+:16], i_src_a[16*i+:16]};
            assign shl_d[32*i+:32] = (i_src_b >= DWORD_LIMIT) ? 32'h0 : a_d << i_src_b[4:0];
            assign shr_d[32*i+:32] = (i_src_b >= DWORD_LIMIT) ? 32'h0 : a_d >> i_src_b[4:0];
            assign sar_d[32*i+:32] = (i_src_b >= DWORD_LIMIT) ? {32{a_d[31]}}
                                   : 32'($signed(a_d) >>> i_src_b[4:0]);
        end
    endgenerate

    assign shl_q = (i_src_b >= QUAD_LIMIT) ? 64'h0 : i_src_a << i_src_b[5:0];
    assign shr_q = (i_src_b >= QUAD_LIMIT) ? 64'h0 : i_src_a >> i_src_b[5:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Result select

    always_comb begin
        case (i_op)
            MOVE_DOUBLE_WORD: result_d = {32'h0, i_src_a[31:0]};
            MOVE_QUAD_WORD: result_d = i_src_a;
            PACK_SIGNED_WORD_TO_BYTE: result_d = pk_sb;
            PACK_SIGNED_DWORD_TO_WORD: result_d = pk_sw;
            PACK_UNSIGNED_WORD_TO_BYTE: result_d = pk_ub;
            INTERLEAVE_HIGH_BYTES: result_d = hi_b;
            INTERLEAVE_HIGH_WORDS: result_d = hi_w;
            INTERLEAVE_HIGH_DWORDS: result_d = {i_src_b[63:32], i_src_a[63:32]};
            INTERLEAVE_LOW_BYTES: result_d = lo_b;
            INTERLEAVE_LOW_WORDS: result_d = lo_w;
            INTERLEAVE_LOW_DWORDS: result_d = {i_src_b[31:0], i_src_a[31:0]};
            LANE_ADD_BYTE, LANE_SUB_BYTE: result_d = b_wrap;
            LANE_ADD_WORD, LANE_SUB_WORD: result_d = w_wrap;
            LANE_ADD_DWORD, LANE_SUB_DWORD: result_d = d_wrap;
            SAT_SIGNED_ADD_BYTE, SAT_SIGNED_SUB_BYTE: result_d = b_ss;
            SAT_SIGNED_ADD_WORD, SAT_SIGNED_SUB_WORD: result_d = w_ss;
            SAT_UNSIGNED_ADD_BYTE, SAT_UNSIGNED_SUB_BYTE: result_d = b_su;
            SAT_UNSIGNED_ADD_WORD, SAT_UNSIGNED_SUB_WORD: result_d = w_su;
            MUL_WORD_HIGH_HALF: result_d = mul_hi;
            MUL_WORD_LOW_HALF: result_d = mul_lo;
            MUL_ADD_WORD_PAIRS: result_d = mul_add;
            CMP_EQUAL_BYTE: result_d = eq_b;
            CMP_EQUAL_WORD: result_d = eq_w;
            CMP_EQUAL_DWORD: result_d = eq_d;
            CMP_GREATER_BYTE: result_d = gt_b;
            CMP_GREATER_WORD: result_d = gt_w;
            CMP_GREATER_DWORD: result_d = gt_d;
            BITWISE_AND_QUAD: result_d = i_src_a & i_src_b;
            BITWISE_AND_INVERTED: result_d = ~i_src_a & i_src_b;
            BITWISE_OR_QUAD: result_d = i_src_a | i_src_b;
            BITWISE_XOR_QUAD: result_d = i_src_a ^ i_src_b;
            SHL_LOGICAL_WORD: result_d = shl_w;
            SHL_LOGICAL_DWORD: result_d = shl_d;
            SHL_LOGICAL_QUAD: result_d = shl_q;
            SHR_LOGICAL_WORD: result_d = shr_w;
            SHR_LOGICAL_DWORD: result_d = shr_d;
            SHR_LOGICAL_QUAD: result_d = shr_q;
            SHR_ARITH_WORD: result_d = sar_w;
            SHR_ARITH_DWORD: result_d = sar_d;
            default: result_d = RESULT_RST;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output registers

    // Result and valid follow one cycle after issue
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_result <= RESULT_RST;
            o_valid <= VALID_RST;
        end else if (i_ce) begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_result <= result_d;
            end
        end
    end

    // Any packed op claims the register set; the empty op frees it
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_state_empty <= EMPTY_RST;
        end else if (i_ce && i_valid) begin
            o_state_empty <= (i_op == EMPTY_PACKED_STATE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    logic fire;
    assign fire = i_ce && i_valid;

    AST_MOVE_QUAD: assert property (
        fire && i_op == MOVE_QUAD_WORD |=> o_result == $past(i_src_a) && o_valid)
        else $error("quad move altered the value");
    AST_PACK_SIGNED: assert property (
        fire && i_op == PACK_SIGNED_WORD_TO_BYTE && !i_src_a[15] && |i_src_a[14:7]
        |=> o_result[7:0] == 8'h7f)
        else $error("signed pack did not clamp to max");
    AST_PACK_UNSIGNED: assert property (
        fire && i_op == PACK_UNSIGNED_WORD_TO_BYTE && i_src_b[15]
        |=> o_result[39:32] == 8'h00)
        else $error("unsigned pack did not clamp negative to zero");
    AST_INTERLEAVE_HIGH: assert property (
        fire && i_op == INTERLEAVE_HIGH_BYTES
        |=> o_result[15:0] == {$past(i_src_b[39:32]), $past(i_src_a[39:32])})
        else $error("high byte interleave wrong");
    AST_INTERLEAVE_LOW: assert property (
        fire && i_op == INTERLEAVE_LOW_WORDS
        |=> o_result[63:32] == {$past(i_src_b[31:16]), $past(i_src_a[31:16])})
        else $error("low word interleave wrong");
    AST_ADD_WRAP: assert property (
        fire && i_op == LANE_ADD_BYTE
        |=> o_result[63:56] == 8'($past(i_src_a[63:56]) + $past(i_src_b[63:56])))
        else $error("byte add did not wrap");
    AST_SAT_SIGNED_ADD: assert property (
        fire && i_op == SAT_SIGNED_ADD_WORD && i_src_a[15:0] == 16'h8000
        && i_src_b[15] |=> o_result[15:0] == 16'h8000)
        else $error("signed add did not clamp to min");
    AST_SAT_UNSIGNED_ADD: assert property (
        fire && i_op == SAT_UNSIGNED_ADD_BYTE && i_src_a[7:0] == 8'hff
        |=> o_result[7:0] == 8'hff)
        else $error("unsigned add did not clamp to max");
    AST_SUB_WRAP: assert property (
        fire && i_op == LANE_SUB_DWORD
        |=> o_result[31:0] == 32'($past(i_src_a[31:0]) - $past(i_src_b[31:0])))
        else $error("dword subtract wrong");
    AST_SAT_SIGNED_SUB: assert property (
        fire && i_op == SAT_SIGNED_SUB_BYTE && i_src_a[7:0] == 8'h7f
        && i_src_b[7] |=> o_result[7:0] == 8'h7f)
        else $error("signed subtract did not clamp to max");
    AST_SAT_UNSIGNED_SUB: assert property (
        fire && i_op == SAT_UNSIGNED_SUB_WORD && i_src_a[15:0] < i_src_b[15:0]
        |=> o_result[15:0] == 16'h0)
        else $error("unsigned subtract did not clamp at zero");
    AST_MUL_HALVES: assert property (
        fire && i_op == MUL_WORD_HIGH_HALF && i_src_a[15:0] == 16'h8000
        && i_src_b[15:0] == 16'h8000 |=> o_result[15:0] == 16'h4000)
        else $error("high multiply half wrong");
    AST_MUL_LOW: assert property (
        fire && i_op == MUL_WORD_LOW_HALF
        |=> o_result[15:0] == 16'($past(i_src_a[15:0]) * $past(i_src_b[15:0])))
        else $error("low multiply half wrong");
    AST_CMP_MASK: assert property (
        fire && (i_op == CMP_EQUAL_WORD || i_op == CMP_GREATER_WORD)
        |=> o_result[15:0] == 16'h0 || o_result[15:0] == 16'hffff)
        else $error("compare lane not a full mask");
    AST_CMP_GREATER: assert property (
        fire && i_op == CMP_GREATER_BYTE && i_src_a[7:0] == 8'h01
        && i_src_b[7:0] == 8'hff |=> o_result[7:0] == 8'hff)
        else $error("signed greater compare wrong");
    AST_AND_INV: assert property (
        fire && i_op == BITWISE_AND_INVERTED
        |=> o_result == (~$past(i_src_a) & $past(i_src_b)))
        else $error("inverted and wrong");
    AST_SHIFT_BIG: assert property (
        fire && i_op == SHR_ARITH_WORD && i_src_b >= WORD_LIMIT
        |=> o_result[15:0] == {16{$past(i_src_a[15])}})
        else $error("oversized arithmetic shift not sign filled");
    AST_SHL_ZERO: assert property (
        fire && i_op == SHL_LOGICAL_DWORD && i_src_b < DWORD_LIMIT && i_src_b != 64'h0
        |=> o_result[0] == 1'b0)
        else $error("left shift did not fill zero");
    AST_EMPTY_STATE: assert property (
        fire && i_op == EMPTY_PACKED_STATE ##1 !fire [*2] |-> o_state_empty)
        else $error("packed state not marked empty");
    AST_CE_FREEZE: assert property (
        !i_ce |=> $stable(o_result) && $stable(o_valid) && $stable(o_state_empty))
        else $error("outputs moved while clock enable was low");
    AST_PACK_DWORD: assert property (
        fire && i_op == PACK_SIGNED_DWORD_TO_WORD && i_src_b[63] && !(&i_src_b[62:47])
        |=> o_result[63:48] == 16'h8000)
        else $error("signed dword pack did not clamp to min");
    AST_MUL_ADD: assert property (
        fire && i_op == MUL_ADD_WORD_PAIRS && i_src_a[15:0] == 16'hffff && i_src_b[31:16] == 16'h0
        |=> o_result[31:0] == 32'h0 - 32'($signed($past(i_src_b[15:0]))))
        else $error("multiply-add pair sum wrong");
    AST_CMP_EQUAL: assert property (
        fire && i_op == CMP_EQUAL_BYTE && i_src_a[39:32] == i_src_b[39:32]
        |=> o_result[39:32] == 8'hff)
        else $error("equal byte compare wrong");
    AST_SHR_LOGIC: assert property (
        fire && i_op == SHR_LOGICAL_QUAD && i_src_b != 64'h0 && i_src_b < QUAD_LIMIT
        |=> !o_result[63])
        else $error("right logical shift did not fill zero");

    COV_SAT_PACK: cover property (fire && i_op == PACK_SIGNED_WORD_TO_BYTE && i_src_a[15]);
    COV_SAT_ADD: cover property (fire && i_op == SAT_UNSIGNED_ADD_WORD ##1 o_valid);
    COV_CMP_TRUE: cover property (fire && i_op == CMP_EQUAL_DWORD && i_src_a == i_src_b);
    COV_EMPTY_REUSE: cover property (fire && i_op == EMPTY_PACKED_STATE ##1 fire);

endmodule : packed_simd_integer_alu

/* issue_model.sv */
// Issue-side model that presents operations to the packed datapath
module issue_model
    import simd_alu_pkg::*;
(
    output logic o_ce,
    output logic o_valid,
    output logic [OP_W-1:0] o_op,
    output logic [DATA_W-1:0] o_a,
    output logic [DATA_W-1:0] o_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_ce = 1'b1;
        o_valid = 1'b0;
        o_op = 6'h00;
        o_a = 64'h0;
        o_b = 64'h0;
    end
    // Called just after a falling edge; everything changes together
    task automatic send(logic [OP_W-1:0] op, logic [DATA_W-1:0] a, logic [DATA_W-1:0] b,
                        logic ce);
        o_ce = ce;
        o_valid = 1'b1;
        o_op = op;
        o_a = a;
        o_b = b;
    endtask : send
    // Idle operands are not held, so stale values cannot leak into a result
    task automatic idle();
        o_ce = 1'b1;
        o_valid = 1'b0;
        o_a = ~o_a;
        o_b = ~o_b;
    endtask : idle
endmodule : issue_model

/* test_packed_simd_integer_alu.sv */
// Self-checking bench for the packed integer datapath
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_packed_simd_integer_alu;
    import simd_alu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic ce, valid, o_valid, o_state_empty;
    logic [OP_W-1:0] op;
    logic [DATA_W-1:0] a, b, o_result;
    logic [63:0] seed = 64'h2;
    int err_total = 0;
    int total_checks = 0;
    localparam int KND[35] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 3, 4, 4, 5, 5, 11, 12, 13, 6, 6, 6,
        7, 7, 7, 14, 15, 16, 17, 8, 8, 8, 9, 9, 9, 10, 10};
    localparam int WID[35] = '{8, 16, 32, 8, 16, 8, 16, 8, 16, 32, 8, 16, 8, 16, 16, 16, 32,
        8, 16, 32, 8, 16, 32, 64, 64, 64, 64, 16, 32, 64, 16, 32, 64, 16, 32};
    localparam logic [63:0] CA[4] = '{64'h7f80_7fff_8000_0001, 64'h8000_1234_8765_ffff,
        64'hffff_0000_8000_7fff, 64'h00ff_7f01_ff80_0080};
    localparam logic [63:0] CB[4] = '{64'h0180_0001_8000_ffff, 64'h10, 64'h1f,
        64'h1_0000_0000};

    always #10 i_ref_clk = ~i_ref_clk;

    issue_model u_iss (.o_ce(ce), .o_valid(valid), .o_op(op), .o_a(a), .o_b(b));
    packed_simd_integer_alu u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(ce),
        .i_valid(valid), .i_op(op), .i_src_a(a), .i_src_b(b), .o_result(o_result),
        .o_valid(o_valid), .o_state_empty(o_state_empty));

    ////////////////////////////////////////////////////////////////////////////////////
    function logic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction : rnd
    function automatic logic [63:0] gl(logic [63:0] x, int w, int k);
        return (x >> (w * k)) & ((w == 64) ? '1 : (64'h1 << w) - 64'h1);
    endfunction : gl
    function automatic longint sx(logic [63:0] x, int w);
        return longint'(x << (64 - w)) >>> (64 - w);
    endfunction : sx
    function automatic longint cl(longint v, longint lo, longint hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : cl
    function automatic logic [63:0] model(logic [5:0] op, logic [63:0] a, logic [63:0] b);
        int w, kd, off;
        longint ua, ub, sa, sb, v, mx, lo, hi;
        logic [63:0] r;
        r = 64'h0;
        if (op == MOVE_DOUBLE_WORD) r = {32'h0, a[31:0]};
        else if (op == MOVE_QUAD_WORD) r = a;
        else if (op <= 6'h04) begin
            w = (op == PACK_SIGNED_DWORD_TO_WORD) ? 32 : 16;
            lo = (op == 6'h02) ? -128 : (op == 6'h03) ? -32768 : 0;
            hi = (op == 6'h02) ? 127 : (op == 6'h03) ? 32767 : 255;
            for (int k = 0; k < 64 / w; k++)
                for (int j = 0; j < 2; j++)
                    r |= gl(cl(sx(gl(j ? b : a, w, k), w), lo, hi), w / 2, 0)
                        << (w / 2 * (k + j * 64 / w));
        end else if (op <= 6'h0a) begin
            w = 8 << ((int'(op) - 5) % 3);
            off = (op <= 6'h07) ? 32 / w : 0;
            for (int k = 0; k < 32 / w; k++)
                for (int j = 0; j < 2; j++)
                    r |= gl(j ? b : a, w, k + off) << (w * (2 * k + j));
        end else if (op <= 6'h2d) begin
            kd = KND[op - 11];
            w = WID[op - 11];
            for (int k = 0; k < 64 / w; k++) begin
                ua = gl(a, w, k);
                ub = gl(b, w, k);
                sa = sx(ua, w);
                sb = sx(ub, w);
                mx = longint'(1) <<< (w - 1);
                case (kd)
                    0: v = ua + ub;
                    1: v = cl(sa + sb, -mx, mx - 1);
                    2: v = cl(ua + ub, 0, 2 * mx - 1);
                    3: v = ua - ub;
                    4: v = cl(sa - sb, -mx, mx - 1);
                    5: v = cl(ua - ub, 0, 2 * mx - 1);
                    6: v = (ua == ub) ? -1 : 0;
                    7: v = (sa > sb) ? -1 : 0;
                    8: v = (b >= w) ? 0 : ua << b;
                    9: v = (b >= w) ? 0 : ua >> b;
                    10: v = (b >= w) ? sa >>> (w - 1) : sa >>> b;
                    11: v = (sa * sb) >>> 16;
                    12: v = sa * sb;
                    13: v = sx(gl(a, 16, 2 * k), 16) * sx(gl(b, 16, 2 * k), 16)
                        + sx(gl(a, 16, 2 * k + 1), 16) * sx(gl(b, 16, 2 * k + 1), 16);
                    14: v = ua & ub;
                    15: v = ~ua & ub;
                    16: v = ua | ub;
                    default: v = ua ^ ub;
                endcase
                r |= gl(v, w, 0) << (w * k);
            end
        end
        return r;
    endfunction : model

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic chk_rst();
        `CHK("reset result", 64'h0, o_result)
        `CHK("reset valid", 1'b0, o_valid)
        `CHK("reset empty", 1'b1, o_state_empty)
    endtask : chk_rst
    // Called at a falling edge; back-to-back calls issue every cycle
    task automatic check_op(logic [5:0] op, logic [63:0] a, logic [63:0] b);
        logic [63:0] ex;
        ex = model(op, a, b);
        u_iss.send(op, a, b, 1'b1);
        @(negedge i_ref_clk);
        `CHK("valid", 1'b1, o_valid)
        `CHK("result", ex, o_result)
        `CHK("empty", op == EMPTY_PACKED_STATE, o_state_empty)
    endtask : check_op

    initial begin
        #(20 * 10000);
        err_total++;
        finish_test();
    end
    initial begin
        logic [63:0] rb;
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk_rst();
        i_rstn = 1'b1;
        for (int c = 0; c < 4; c++)
            for (int o = 0; o < 48; o++)
                check_op(6'(o), CA[c], CB[c]);
        check_op(LANE_ADD_BYTE, 64'h0102_0304_0506_0708, 64'hff);
        u_iss.send(LANE_SUB_BYTE, 64'h55, 64'h11, 1'b0);
        @(negedge i_ref_clk);
        `CHK("frozen result", 64'h0102_0304_0506_0707, o_result)
        `CHK("frozen valid", 1'b1, o_valid)
        u_iss.idle();
        @(negedge i_ref_clk);
        `CHK("idle valid", 1'b0, o_valid)
        `CHK("held result", 64'h0102_0304_0506_0707, o_result)
        repeat (2000) begin
            rb = rnd();
            if (rb[0])
                rb = rb % 70;
            check_op(6'(rnd() % 48), rnd(), rb);
        end
        check_op(BITWISE_XOR_QUAD, rnd(), rnd());
        i_rstn = 1'b0;
        #1;
        chk_rst();
        @(negedge i_ref_clk);
        i_rstn = 1'b1;
        check_op(EMPTY_PACKED_STATE, rnd(), rnd());
        u_iss.idle();
        repeat (2) @(negedge i_ref_clk);
        `CHK("empty held", 1'b1, o_state_empty)
        `CHK("idle valid after empty", 1'b0, o_valid)
        finish_test();
    end
endmodule : test_packed_simd_integer_alu
